//--- common/hcbs_pkg.sv
// Constants, field layouts and carriers of the host command front end.
// Assumes one core clock of 200 MHz and a 16-byte register window.
package hcbs_pkg;
    localparam int CLK_PS = 5000;
    localparam int EE_HALF_NS = 500;
    localparam int EE_HALF_CYC = (EE_HALF_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CHK_NS = 1000;
    localparam int CHK_CYC = (CHK_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam logic [7:0] STRAP_CYC = 8'h03;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [1:0] BANK_0 = 2'h0;
    localparam logic [1:0] BANK_BAD = 2'h3;
    localparam logic [4:0] OPC_BANK = 5'h00;
    localparam int BANK_POINTER_LSB = 6;
    localparam int ST_RX_INT = 0;
    localparam int ST_TX_INT = 1;
    localparam int ST_EVT_FLAG = 3;
    localparam logic [15:0] EE_BLANK = 16'hFFFF;
    localparam logic [15:0] EE_ERASED = 16'h0000;
    localparam logic [8:0] EE_RD_CMD = 9'h180;
    localparam logic [4:0] EE_CMD_BITS = 5'h09;
    localparam logic [4:0] EE_LAST_BIT = 5'h18;
    localparam int EE_AUTOCFG = 3;
    localparam int EE_BASE_LSB = 4;
    localparam int EE_FLASH = 10;
    localparam int EE_AUTO_IO = 11;
    localparam int EE_BOOT_LSB = 12;
    localparam int EE_BUS16 = 15;
    localparam logic [9:0] IO_FALLBACK = 10'h300;
    localparam logic [9:0] IO_STEP = 10'h010;

    typedef struct packed {
        logic [9:0] io_base;
        logic flash_det;
        logic auto_io;
        logic [2:0] boot_win;
        logic bus16;
        logic autocfg;
    } hcbs_cfg_s;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic [3:0] addr;
        logic [7:0] din;
        logic conflict;
        logic pcmcia;
        logic port_sel;
        logic [1:0] eedo;
    } hcbs_pin_s;

    typedef struct packed {
        logic cs;
        logic sk;
        logic di;
    } hcbs_ee_s;

    typedef enum logic [1:0] {
        INI_STRAP = 2'b00,
        INI_WAIT = 2'b01,
        INI_CHECK = 2'b10,
        INI_DONE = 2'b11
    } hcbs_ini_e;
endpackage

//--- verilog/hcbs_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes every bit is a slow level; the bundle is not kept coherent.
`timescale 1ns/10ps
module hcbs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RV = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= RV;
            q <= RV;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

//--- verilog/hcbs_ee_rd.sv
// Serial EEPROM reader: fetches word 0 with one read command.
// Assumes the data-out pin is already synchronised (about 3 cycles late).
`timescale 1ns/10ps
module hcbs_ee_rd #(
    parameter logic [7:0] HALF = 8'(hcbs_pkg::EE_HALF_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic dout_in,
    output hcbs_pkg::hcbs_ee_s pins,
    output logic done,
    output logic [15:0] word
);
    import hcbs_pkg::*;

    typedef struct packed {
        logic busy;
        hcbs_ee_s ee;
        logic [7:0] cnt;
        logic [4:0] bitn;
        logic [8:0] cmd;
        logic [15:0] sh;
        logic done;
    } hcbs_eer_s;

    hcbs_eer_s q_reg;
    hcbs_eer_s q_next;

    always_comb
    begin
        q_next = q_reg;
        q_next.done = 1'b0;
        if (!q_reg.busy)
        begin
            if (start)
            begin
                q_next.busy = 1'b1;
                q_next.ee = '{cs: 1'b1, sk: 1'b0, di: EE_RD_CMD[8]};
                q_next.cmd = {EE_RD_CMD[7:0], 1'b0};
                q_next.bitn = '0;
                q_next.cnt = HALF - 8'h01;
            end
        end
        else if (q_reg.cnt != 8'h00)
            q_next.cnt = q_reg.cnt - 8'h01;
        else
        begin
            q_next.cnt = HALF - 8'h01;
            if (!q_reg.ee.sk)
                q_next.ee.sk = 1'b1;
            else
            begin
                // Sample late in the high half to cover the pin delay
                q_next.ee.sk = 1'b0;
                q_next.ee.di = q_reg.cmd[8];
                q_next.cmd = {q_reg.cmd[7:0], 1'b0};
                q_next.bitn = q_reg.bitn + 5'h01;
                if (q_reg.bitn >= EE_CMD_BITS)
                    q_next.sh = {q_reg.sh[14:0], dout_in};
                if (q_reg.bitn == EE_LAST_BIT)
                begin
                    q_next.busy = 1'b0;
                    q_next.ee = '0;
                    q_next.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q_reg <= '0;
        else
            q_reg <= q_next;
    end

    assign pins = q_reg.ee;
    assign done = q_reg.done;
    assign word = q_reg.sh;
endmodule

//--- verilog/hcbs_top.sv
// Host command register, bank select, status and reset-time config load.
// Assumes host IO strobes arrive as pins and are held past 3 clocks.
// Functional notes
// [RULE1] Command register answers at offset 0 whatever bank is selected.
// [RULE2] Host writes a command code into bits 4..0; accepted any time.
// [RULE3] Command conflicting with current activity is dropped, no event.
// [RULE4] Read opcode shows last completed non-transmit event, valid with flag.
// [RULE5] Bit 5 is read-only: last execution command was aborted.
// [RULE6] Host should write bit 5 as zero on every command write.
// [RULE7] Pointer bits 7..6: 00 bank 0, 01 bank 1, 10 bank 2.
// [RULE8] Pointer bits act only with the bank-switch code 0h.
// [RULE9] Selected bank holds until switched; reset selects bank 0.
// [RULE10] Reading the command register returns the current bank.
// [RULE11] Bank 0 register 1 shows interrupts, receive and execution state.
// [RULE12] After any reset in ISA mode, fetch EEPROM word 0 and apply it.
// [RULE13] Word all ones or all zeros falls back to IO base 300h.
// [RULE14] With auto IO, move the IO window on a conflict during init.
// [RULE15] PCMCIA mode skips the EEPROM load and uses default settings.
// [RULE16] Only one EEPROM port is active; fetches use the selected one.
// [RULE17] Concurrent transmit: host sets addresses, copies part, then commands.
// [RULE18] Non-concurrent transmit: host copies whole frame before commanding.
// [RULE19] Frame results go to memory structures, not to these registers.
// [RULE20] Other opcodes are parameters; undefined codes are ignored.
`timescale 1ns/10ps
module hcbs_top #(
    parameter logic [4:0] OPC_CONFIG = 5'h02,
    parameter logic [4:0] OPC_MC = 5'h03,
    parameter logic [4:0] OPC_TX = 5'h04,
    parameter logic [4:0] OPC_TDR = 5'h05,
    parameter logic [4:0] OPC_DUMP = 5'h06,
    parameter logic [4:0] OPC_DIAG = 5'h07,
    parameter logic [4:0] OPC_SWRST = 5'h0E
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire hcbs_pkg::hcbs_pin_s PINS,
    input wire logic TX_BUSY,
    input wire logic EXEC_BUSY,
    input wire logic [1:0] RX_STATE,
    input wire logic EXEC_DONE,
    input wire logic [4:0] EXEC_CODE,
    input wire logic EXEC_ABORTED,
    input wire logic TX_DONE,
    input wire logic RX_DONE,
    output logic [7:0] IO_DOUT,
    output logic IO_DOUT_OE_N,
    output logic [1:0] BANK,
    output logic CMD_GO,
    output logic [4:0] CMD_CODE,
    output hcbs_pkg::hcbs_cfg_s CFG,
    output logic CFG_VALID,
    output hcbs_pkg::hcbs_ee_s EE1,
    output hcbs_pkg::hcbs_ee_s EE2
);
    import hcbs_pkg::*;

    localparam hcbs_pin_s PIN_RV = '{rd_n: 1'b1, wr_n: 1'b1, default: '0};
    localparam logic [7:0] CHK_LOAD = 8'(CHK_CYC - 1);

    typedef struct packed {
        logic [1:0] bank;
        logic [4:0] op_st;
        logic abort;
        logic evt_flag;
        logic tx_int;
        logic rx_int;
        hcbs_ini_e ini;
        logic [7:0] cnt;
        hcbs_cfg_s cfg;
        logic cfg_ok;
        logic pcm;
        logic psel;
        logic ee_go;
        logic rd_d;
        logic wr_d;
        logic [7:0] dout;
        logic doe_n;
        logic go;
        logic [4:0] code;
        hcbs_ee_s ee1;
        hcbs_ee_s ee2;
    } hcbs_top_s;

    hcbs_top_s q_reg;
    hcbs_top_s q_next;
    hcbs_pin_s ps;
    hcbs_ee_s ee_pins;
    logic ee_done;
    logic [15:0] ee_word;
    logic ee_din;
    logic rd_on;
    logic wr_on;
    logic rd_ev;
    logic wr_ev;
    logic cmd_wr;
    logic [4:0] wr_op;
    logic rd_hit;
    logic [7:0] rdata;

    function automatic logic is_exec(input logic [4:0] c);
        return c == OPC_CONFIG || c == OPC_MC || c == OPC_TDR ||
            c == OPC_DUMP || c == OPC_DIAG;
    endfunction

    function automatic hcbs_cfg_s ee_decode(input logic [15:0] w);
        hcbs_cfg_s c;
        c.io_base = {w[EE_BASE_LSB +: 6], 4'h0};
        c.flash_det = w[EE_FLASH];
        c.auto_io = w[EE_AUTO_IO];
        c.boot_win = w[EE_BOOT_LSB +: 3];
        c.bus16 = w[EE_BUS16];
        c.autocfg = w[EE_AUTOCFG];
        // [RULE13] blank word fallback
        if (w == EE_BLANK || w == EE_ERASED)
        begin
            c = '0;
            c.io_base = IO_FALLBACK;
        end
        return c;
    endfunction

    hcbs_sync #(
        .W($bits(hcbs_pin_s)),
        .RV(PIN_RV)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d(PINS),
        .q(ps)
    );

    // [RULE16] single active port feeds the reader
    assign ee_din = q_reg.psel ? ps.eedo[1] : ps.eedo[0];

    hcbs_ee_rd u_ee (
        .clk(CORE_CLK),
        .rst(RST),
        .start(q_reg.ee_go),
        .dout_in(ee_din),
        .pins(ee_pins),
        .done(ee_done),
        .word(ee_word)
    );

    assign rd_on = !ps.rd_n;
    assign wr_on = !ps.wr_n;
    assign rd_ev = rd_on && !q_reg.rd_d;
    assign wr_ev = wr_on && !q_reg.wr_d;
    // [RULE1] offset 0 decoded without the bank
    assign cmd_wr = wr_ev && ps.addr == REG_CMD;
    assign wr_op = ps.din[4:0];

    // [RULE11] status view in bank 0 only
    always_comb
    begin
        rd_hit = 1'b1;
        rdata = '0;
        if (ps.addr == REG_CMD)
            rdata = {q_reg.bank, q_reg.abort, q_reg.op_st};
        else if (ps.addr == REG_STAT && q_reg.bank == BANK_0)
            rdata = {RX_STATE, 1'b0, EXEC_BUSY, q_reg.evt_flag, 1'b0,
                q_reg.tx_int, q_reg.rx_int};
        else
            rd_hit = 1'b0;
    end

    always_comb
    begin
        q_next = q_reg;
        q_next.go = 1'b0;
        q_next.ee_go = 1'b0;
        q_next.rd_d = rd_on;
        q_next.wr_d = wr_on;

        // [RULE10] read returns live bank
        if (rd_ev && rd_hit)
        begin
            q_next.dout = rdata;
            q_next.doe_n = 1'b0;
        end
        else if (!rd_on)
            q_next.doe_n = 1'b1;

        // Clear first so a same-cycle event wins
        if (wr_ev && ps.addr == REG_STAT && q_reg.bank == BANK_0)
        begin
            if (ps.din[ST_RX_INT])
                q_next.rx_int = 1'b0;
            if (ps.din[ST_TX_INT])
                q_next.tx_int = 1'b0;
            if (ps.din[ST_EVT_FLAG])
                q_next.evt_flag = 1'b0;
        end
        // [RULE19] only a flag, no frame result
        if (TX_DONE)
            q_next.tx_int = 1'b1;
        if (RX_DONE)
            q_next.rx_int = 1'b1;
        // [RULE4] [RULE5] completion code and abort
        if (EXEC_DONE)
        begin
            q_next.evt_flag = 1'b1;
            q_next.op_st = EXEC_CODE;
            q_next.abort = EXEC_ABORTED;
        end

        // [RULE2] command decode, bit 5 ignored
        if (cmd_wr)
        begin
            // [RULE7] [RULE8] pointer only with switch code
            if (wr_op == OPC_BANK)
            begin
                if (ps.din[BANK_POINTER_LSB +: 2] != BANK_BAD)
                    q_next.bank = ps.din[BANK_POINTER_LSB +: 2];
            end
            else if (wr_op == OPC_SWRST)
                q_next.bank = BANK_0;
            // [RULE3] busy unit drops the command
            else if (wr_op == OPC_TX)
            begin
                if (!TX_BUSY)
                begin
                    q_next.go = 1'b1;
                    q_next.code = wr_op;
                end
            end
            // [RULE20] unknown codes fall through
            else if (is_exec(wr_op) && !EXEC_BUSY)
            begin
                q_next.go = 1'b1;
                q_next.code = wr_op;
            end
        end

        unique case (q_reg.ini)
            INI_STRAP:
            begin
                // Wait for the strap pins to pass the synchroniser
                if (q_reg.cnt != 8'h00)
                    q_next.cnt = q_reg.cnt - 8'h01;
                // [RULE15] card mode skips the fetch
                else if (ps.pcmcia)
                begin
                    q_next.pcm = 1'b1;
                    q_next.cfg = '0;
                    q_next.cfg.io_base = IO_FALLBACK;
                    q_next.cfg_ok = 1'b1;
                    q_next.ini = INI_DONE;
                end
                // [RULE12] fetch word 0
                else
                begin
                    q_next.pcm = 1'b0;
                    q_next.psel = ps.port_sel;
                    q_next.ee_go = 1'b1;
                    q_next.ini = INI_WAIT;
                end
            end
            INI_WAIT:
            begin
                // [RULE12] apply fetched settings
                if (ee_done)
                begin
                    q_next.cfg = ee_decode(ee_word);
                    q_next.cnt = CHK_LOAD;
                    if (q_next.cfg.auto_io)
                        q_next.ini = INI_CHECK;
                    else
                    begin
                        q_next.cfg_ok = 1'b1;
                        q_next.ini = INI_DONE;
                    end
                end
            end
            INI_CHECK:
            begin
                // [RULE14] step past a claimed window
                if (ps.conflict)
                begin
                    q_next.cfg.io_base = q_reg.cfg.io_base + IO_STEP;
                    q_next.cnt = CHK_LOAD;
                end
                else if (q_reg.cnt != 8'h00)
                    q_next.cnt = q_reg.cnt - 8'h01;
                else
                begin
                    q_next.cfg_ok = 1'b1;
                    q_next.ini = INI_DONE;
                end
            end
            INI_DONE:
            begin
                q_next.ini = INI_DONE;
            end
        endcase

        // [RULE12] software reset restarts init
        // Placed after the sequencer so no state branch can undo it
        if (cmd_wr && wr_op == OPC_SWRST)
        begin
            q_next.ini = INI_STRAP;
            q_next.cnt = STRAP_CYC;
            q_next.cfg_ok = 1'b0;
        end

        // [RULE16] idle port held quiet
        q_next.ee1 = (q_reg.psel || q_reg.pcm) ? '0 : ee_pins;
        q_next.ee2 = (!q_reg.psel || q_reg.pcm) ? '0 : ee_pins;
    end

    // [RULE9] reset selects bank 0
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            q_reg <= '0;
            q_reg.doe_n <= 1'b1;
            q_reg.cnt <= STRAP_CYC;
            q_reg.ini <= INI_STRAP;
        end
        else
            q_reg <= q_next;
    end

    assign IO_DOUT = q_reg.dout;
    assign IO_DOUT_OE_N = q_reg.doe_n;
    assign BANK = q_reg.bank;
    assign CMD_GO = q_reg.go;
    assign CMD_CODE = q_reg.code;
    assign CFG = q_reg.cfg;
    assign CFG_VALID = q_reg.cfg_ok;
    assign EE1 = q_reg.ee1;
    assign EE2 = q_reg.ee2;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    bank_hold_a: assert property ( // [RULE9]
        !(cmd_wr && (wr_op == OPC_BANK || wr_op == OPC_SWRST))
        |=> q_reg.bank == $past(q_reg.bank))
        else $error("bank changed without a switch");
    bank_set_a: assert property ( // [RULE8]
        cmd_wr && wr_op == OPC_BANK && ps.din[7:6] != BANK_BAD
        |=> q_reg.bank == $past(ps.din[7:6]) && !q_reg.go)
        else $error("bank switch not applied");
    cmd_drop_a: assert property ( // [RULE3]
        cmd_wr && wr_op == OPC_TX && TX_BUSY |=> !q_reg.go)
        else $error("conflicting transmit not dropped");
    cmd_take_a: assert property ( // [RULE2]
        cmd_wr && wr_op == OPC_TX && !TX_BUSY
        |=> q_reg.go && q_reg.code == OPC_TX ##1 !q_reg.go)
        else $error("transmit command not issued once");
    undef_drop_a: assert property ( // [RULE20]
        q_reg.go |-> q_reg.code == OPC_TX || is_exec(q_reg.code))
        else $error("undefined code issued");
    cmd_read_a: assert property ( // [RULE10]
        rd_ev && ps.addr == REG_CMD
        |=> !q_reg.doe_n && q_reg.dout[7:6] == $past(q_reg.bank))
        else $error("read lost the current bank");
    abort_only_a: assert property ( // [RULE5]
        !EXEC_DONE |=> q_reg.abort == $past(q_reg.abort))
        else $error("abort bit changed without an event");
    exec_code_a: assert property ( // [RULE4]
        EXEC_DONE |=> q_reg.evt_flag && q_reg.op_st == $past(EXEC_CODE))
        else $error("completion code not latched");
    stat_read_a: assert property ( // [RULE11]
        rd_ev && ps.addr == REG_STAT && q_reg.bank == BANK_0
        |=> q_reg.dout[ST_EVT_FLAG] == $past(q_reg.evt_flag) && !q_reg.doe_n)
        else $error("status register misread");
    blank_word_a: assert property ( // [RULE13]
        q_reg.ini == INI_WAIT && ee_done && (ee_word == EE_BLANK || ee_word == EE_ERASED)
        |=> q_reg.cfg.io_base == IO_FALLBACK)
        else $error("blank word did not fall back");
    card_skip_a: assert property ( // [RULE15]
        q_reg.pcm |-> !q_reg.ee1.cs && !q_reg.ee2.cs && !q_reg.ee_go)
        else $error("card mode touched the eeprom");
    one_port_a: assert property ( // [RULE16]
        !(q_reg.ee1.cs && q_reg.ee2.cs))
        else $error("both eeprom ports active");

    bank_two_c: cover property (cmd_wr && wr_op == OPC_BANK ##1 q_reg.bank == 2'h2);
    exec_read_c: cover property (EXEC_DONE ##[1:20] rd_ev && ps.addr == REG_CMD);
    cfg_done_c: cover property (q_reg.ini == INI_WAIT ##1 q_reg.ini == INI_DONE);
endmodule

//--- bench/hcbs_ee_model.sv
// Serial EEPROM model for one configuration port.
// Assumes a 9-bit read command on di, then 16 data bits clocked out.
`timescale 1ns/10ps
module hcbs_ee_model (
    input wire hcbs_pkg::hcbs_ee_s pins,
    input wire logic [15:0] word,
    output logic dout
);
    import hcbs_pkg::*;
    logic [4:0] cnt_reg;
    logic [8:0] cmd_reg;
    initial
    begin
        cnt_reg = 5'h00;
        cmd_reg = 9'h000;
        dout = 1'b0;
    end
    always @(posedge pins.sk or negedge pins.cs)
    begin
        // Released line flips, never holds the last bit
        if (!pins.cs)
        begin
            cnt_reg <= 5'h00;
            dout <= ~dout;
        end
        else
        begin
            if (cnt_reg < EE_CMD_BITS)
                cmd_reg <= {cmd_reg[7:0], pins.di};
            else if (cmd_reg == EE_RD_CMD)
                dout <= word[EE_LAST_BIT - cnt_reg];
            else
                dout <= ~dout;
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
endmodule

//--- bench/tb_top.sv
// Host IO bench: register tasks, EEPROM models on both ports.
// Assumes host strobes held 4 cycles and set-up 3 cycles ahead.
`timescale 1ns/10ps
module tb_top;
    import hcbs_pkg::*;
    localparam int CEIL = 60000;
    logic clk, rst, rd_n, wr_n, conflict, pcmcia, port_sel, oe, ee_seen;
    logic tx_busy, exec_busy, exec_done, exec_ab, tx_done, rx_done;
    logic [3:0] addr;
    logic [7:0] din, rdat, dout;
    logic [1:0] rx_state, bank;
    logic [4:0] exec_code, cmd_code;
    logic [15:0] w1, w2;
    logic dout_oe_n, cmd_go, cfg_valid;
    logic [4:0] op_t [9];
    wire [1:0] eedo;
    hcbs_pin_s pins;
    hcbs_cfg_s cfg, ecfg;
    hcbs_ee_s ee1, ee2;
    int fail_count, n_tests, cycles, go_n, i, n;
    assign pins = {rd_n, wr_n, addr, din, conflict, pcmcia, port_sel, eedo};
    hcbs_top uut (.CORE_CLK(clk), .RST(rst), .PINS(pins), .TX_BUSY(tx_busy),
        .EXEC_BUSY(exec_busy), .RX_STATE(rx_state), .EXEC_DONE(exec_done),
        .EXEC_CODE(exec_code), .EXEC_ABORTED(exec_ab), .TX_DONE(tx_done),
        .RX_DONE(rx_done), .IO_DOUT(dout), .IO_DOUT_OE_N(dout_oe_n), .BANK(bank),
        .CMD_GO(cmd_go), .CMD_CODE(cmd_code), .CFG(cfg), .CFG_VALID(cfg_valid),
        .EE1(ee1), .EE2(ee2));
    hcbs_ee_model ee1_m (.pins(ee1), .word(w1), .dout(eedo[0]));
    hcbs_ee_model ee2_m (.pins(ee2), .word(w2), .dout(eedo[1]));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic results();
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Falling edge: registered outputs are settled there
    always @(negedge clk)
    begin
        cycles++;
        if (cmd_go === 1'b1)
            go_n++;
        if (ee1.cs === 1'b1 || ee2.cs === 1'b1)
            ee_seen = 1'b1;
        if (cycles == CEIL)
        begin
            fail_count++;
            results();
        end
    end
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr = a;
        din = d;
        cyc(3);
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(4);
    endtask
    task automatic rd(input logic [3:0] a);
        addr = a;
        cyc(3);
        rd_n = 1'b0;
        cyc(4);
        rdat = dout;
        oe = dout_oe_n;
        rd_n = 1'b1;
        cyc(4);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk("read_oe_n", 32'(oe), 32'h0);
        chk("read_data", 32'(rdat), 32'(e));
    endtask
    task automatic wait_valid();
        int k;
        for (k = 0; k < 8000 && cfg_valid !== 1'b1; k++)
            cyc(1);
        chk("cfg_valid", 32'(cfg_valid), 32'h1);
    endtask
    function automatic hcbs_cfg_s dec(input logic [15:0] w);
        hcbs_cfg_s c;
        c = '0;
        if (w === EE_BLANK || w === EE_ERASED)
            c.io_base = IO_FALLBACK;
        else
        begin
            c.io_base = {w[9:4], 4'h0};
            c.autocfg = w[3];
            c.flash_det = w[10];
            c.auto_io = w[11];
            c.boot_win = w[14:12];
            c.bus16 = w[15];
        end
        return c;
    endfunction
    initial
    begin
        {conflict, pcmcia, port_sel, tx_busy, exec_busy, exec_done} = 6'h00;
        {exec_ab, tx_done, rx_done, rx_state, exec_code, addr, din} = 22'h0;
        {rd_n, wr_n, rst, ee_seen} = 4'hE;
        {fail_count, n_tests, cycles, go_n} = '0;
        w1 = 16'hA5A8;
        w2 = 16'h0830;
        op_t = '{uut.OPC_CONFIG, uut.OPC_MC, uut.OPC_TX, uut.OPC_TDR, uut.OPC_DUMP,
            uut.OPC_DIAG, uut.OPC_TX, uut.OPC_DIAG, 5'h1F};
        cyc(20);
        chk("bank_rst", 32'(bank), 32'h0);
        chk("oe_rst", 32'(dout_oe_n), 32'h1);
        rst = 1'b0;
        cyc(100);
        chk("ee1_cs", 32'(ee1.cs), 32'h1);
        chk("ee2_idle", 32'(ee2), 32'h0);
        wait_valid();
        chk("cfg_p1", 32'(cfg), 32'(dec(w1)));
        rdc(REG_CMD, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            wr(REG_CMD, {2'(i), 1'b0, OPC_BANK});
            chk("bank", 32'(bank), 32'(i));
            rdc(REG_CMD, {2'(i), 6'h00});
        end
        wr(REG_CMD, {BANK_BAD, 1'b0, OPC_BANK});
        rdc(REG_CMD, 8'h80);
        // Pointer 01 rides on every code but must not switch
        for (i = 0; i < 9; i++)
        begin
            tx_busy = (i == 6);
            exec_busy = (i == 7);
            n = go_n;
            // Frame taken as already staged before each transmit code
            wr(REG_CMD, {2'b01, 1'b0, op_t[i]});
            chk("go_count", 32'(go_n - n), 32'(i < 6));
            if (i < 6)
                chk("cmd_code", 32'(cmd_code), 32'(op_t[i]));
            chk("bank_hold", 32'(bank), 32'h2);
        end
        {tx_busy, exec_busy} = 2'b00;
        wr(REG_CMD, 8'h00);
        exec_code = uut.OPC_DIAG;
        {exec_ab, exec_done} = 2'b11;
        cyc(1);
        {exec_ab, exec_done} = 2'b00;
        rdc(REG_CMD, {3'b001, uut.OPC_DIAG});
        rx_state = 2'b10;
        {exec_busy, tx_done, rx_done} = 3'b111;
        cyc(1);
        {tx_done, rx_done} = 2'b00;
        rdc(REG_STAT, 8'h9B);
        wr(REG_STAT, 8'h0B);
        rdc(REG_STAT, 8'h90);
        exec_busy = 1'b0;
        wr(REG_CMD, 8'h40);
        rd(REG_STAT);
        chk("oe_bank1", 32'(oe), 32'h1);
        port_sel = 1'b1;
        wr(REG_CMD, {3'b000, uut.OPC_SWRST});
        chk("bank_swrst", 32'(bank), 32'h0);
        chk("valid_swrst", 32'(cfg_valid), 32'h0);
        for (i = 0; i < 50 && ee2.cs !== 1'b1; i++)
            cyc(1);
        chk("ee2_cs", 32'(ee2.cs), 32'h1);
        chk("ee1_idle", 32'(ee1), 32'h0);
        for (i = 0; i < 6000 && ee2.cs !== 1'b0; i++)
            cyc(1);
        cyc(20);
        conflict = 1'b1;
        cyc(1);
        conflict = 1'b0;
        wait_valid();
        ecfg = dec(w2);
        ecfg.io_base = ecfg.io_base + IO_STEP;
        chk("cfg_moved", 32'(cfg), 32'(ecfg));
        for (i = 0; i < 2; i++)
        begin
            w2 = (i == 0) ? EE_BLANK : EE_ERASED;
            wr(REG_CMD, {3'b000, uut.OPC_SWRST});
            wait_valid();
            chk("cfg_blank", 32'(cfg), 32'(dec(w2)));
        end
        pcmcia = 1'b1;
        ee_seen = 1'b0;
        wr(REG_CMD, {3'b000, uut.OPC_SWRST});
        wait_valid();
        chk("cfg_card", 32'(cfg), 32'(dec(EE_BLANK)));
        chk("ee_quiet", 32'(ee_seen), 32'h0);
        results();
    end
endmodule
